/* reclock_ctl_pkg.sv */
// Package: register map, field positions, reset values and codes for the output select control
package reclock_ctl_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_STATUS_LOCK = 8'h01;
    localparam logic [7:0] ADDR_PIN_OVERRIDE = 8'h09;
    localparam logic [7:0] ADDR_DRV_CFG_A = 8'h11;
    localparam logic [7:0] ADDR_LEVEL_CTL = 8'h12;
    localparam logic [7:0] ADDR_DEEMPH = 8'h13;
    localparam logic [7:0] ADDR_MUTE_LEVEL = 8'h14;
    localparam logic [7:0] ADDR_RATE_VALUE = 8'h1c;
    localparam logic [7:0] ADDR_RATE_OVR = 8'h1d;
    localparam logic [7:0] ADDR_MANUAL_SEL = 8'h1e;
    localparam logic [7:0] ADDR_REF_STATUS = 8'h41;

    // Field positions
    localparam int LOCK_BIT = 4;
    localparam int OVERRIDE_BIT = 5;
    localparam int CM_LSB = 6;
    localparam int PD_A_BIT = 4;
    localparam int PD_B_BIT = 3;
    localparam int INV_BIT = 0;
    localparam int SWING_A_LSB = 6;
    localparam int SWING_B_LSB = 4;
    localparam int BYPASS_BIT = 2;
    localparam int MUTE_BIT = 1;
    localparam int CLK_EN_BIT = 0;
    localparam int DEEMPH_A_LSB = 6;
    localparam int DEEMPH_B_LSB = 4;
    localparam int MUTE_LEVEL_BIT = 7;
    localparam int RATE_LSB = 0;
    localparam int RATE_OVR_BIT = 0;
    localparam int SEL_A_LSB = 5;
    localparam int SEL_B_LSB = 3;
    localparam int REF_BIT = 3;

    // Reset values: largest swing, highest common mode, no de-emphasis
    localparam logic [7:0] RST_PIN_OVERRIDE = 8'h00;
    localparam logic [7:0] RST_DRV_CFG_A = 8'hc0;
    localparam logic [7:0] RST_LEVEL_CTL = 8'hf0;
    localparam logic [7:0] RST_DEEMPH = 8'h00;
    localparam logic [7:0] RST_MUTE_LEVEL = 8'h00;
    localparam logic [7:0] RST_RATE_VALUE = 8'h00;
    localparam logic [7:0] RST_RATE_OVR = 8'h00;
    localparam logic [7:0] RST_MANUAL_SEL = 8'h00;

    // Output source codes
    typedef enum logic [1:0] {
        SRC_MUTE = 2'b00,
        SRC_RECLOCKED = 2'b01,
        SRC_BYPASSED = 2'b10,
        SRC_CLOCK = 2'b11
    } out_src_t;

    // Rate selection codes
    localparam logic [1:0] RATE_AUTO_VIDEO = 2'b00;
    localparam logic [1:0] RATE_SD_ONLY = 2'b01;
    localparam logic [1:0] RATE_HD_3G = 2'b10;
    localparam logic [1:0] RATE_LOW = 2'b11;

endpackage : reclock_ctl_pkg

/* sample_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
module sample_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("DEPTH must be a power of two, at least 2");
    end

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage write
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end

    // Pointers and occupancy
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : sample_fifo

/* reclock_ctl.sv */
// Output select and driver control for a serial video reclocker
// What this block does
// [R01] Per-output two-bit swing, largest by default
// [R02] Shared common-mode field, highest level default
// [R03] Per-output de-emphasis, off after reset
// [R04] Polarity invert bit flips both outputs
// [R05] Separate power-down bits per output
// [R06] Lock on pin and register, never in bypass
// [R07] Mute forces constant level, beats bypass
// [R08] Pin mode mute pin active low
// [R09] Register mute; mute level bit selects one
// [R10] Bypass sends raw data; clock output muted
// [R11] Unsupported rate forces automatic bypass
// [R12] Bypass from pin or register bit
// [R13] Clock output muted on bypass or unlock
// [R14] Clock enable from pin or register
// [R15] Default selection table without override
// [R16] Override selects manually; bypass still honoured
// [R17] Manual first output decode
// [R18] Manual second output decode
// [R19] Rate pins select allowed lock rates
// [R20] Rate register replaces pins when overridden
// [R21] Reference presence reported in register
// [R22] Mode pin: low pins, high registers
// [R23] Ascending code maps, documented reset defaults
// [R24] Selection recomputed from current inputs
module reclock_ctl (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Mode and control pins
    input wire logic reg_mode_i,
    input wire logic mute_pin_n_i,
    input wire logic bypass_pin_i,
    input wire logic clock_out_enable_pin_i,
    input wire logic rate_pin_low_i,
    input wire logic rate_pin_high_i,
    // Status from the analog core
    input wire logic pll_locked_i,
    input wire logic rate_unsupported_i,
    input wire logic reference_present_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Driver controls
    output logic [1:0] out_a_swing_o,
    output logic [1:0] out_b_swing_o,
    output logic [1:0] outputs_common_mode_o,
    output logic [1:0] out_a_deemphasis_o,
    output logic [1:0] out_b_deemphasis_o,
    output logic outputs_invert_o,
    output logic out_a_powerdown_o,
    output logic out_b_powerdown_o,
    output logic [1:0] out_a_source_o,
    output logic [1:0] out_b_source_o,
    output logic muted_level_o,
    output logic lock_o,
    output logic [1:0] rate_sel_o,
    output logic eye_monitor_allowed_o,
    // Selection change log, drained by the host side
    output logic [3:0] sel_log_data_o,
    output logic sel_log_valid_o,
    input wire logic sel_log_ready_i,
    output logic sel_log_overflow_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] pin_override;
    logic [7:0] drv_cfg_a;
    logic [7:0] level_ctl;
    logic [7:0] deemph;
    logic [7:0] mute_level;
    logic [7:0] rate_value;
    logic [7:0] rate_ovr;
    logic [7:0] manual_sel;

    // Register writes; reset values give the documented defaults
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pin_override <= reclock_ctl_pkg::RST_PIN_OVERRIDE;
            drv_cfg_a <= reclock_ctl_pkg::RST_DRV_CFG_A; // [R02] [R23]
            level_ctl <= reclock_ctl_pkg::RST_LEVEL_CTL; // [R01] [R23]
            deemph <= reclock_ctl_pkg::RST_DEEMPH; // [R03] [R23]
            mute_level <= reclock_ctl_pkg::RST_MUTE_LEVEL;
            rate_value <= reclock_ctl_pkg::RST_RATE_VALUE;
            rate_ovr <= reclock_ctl_pkg::RST_RATE_OVR;
            manual_sel <= reclock_ctl_pkg::RST_MANUAL_SEL;
        end
        else if (reg_write_i)
        begin
            unique case (reg_addr_i)
                reclock_ctl_pkg::ADDR_PIN_OVERRIDE: pin_override <= reg_wdata_i;
                reclock_ctl_pkg::ADDR_DRV_CFG_A: drv_cfg_a <= reg_wdata_i;
                reclock_ctl_pkg::ADDR_LEVEL_CTL: level_ctl <= reg_wdata_i;
                reclock_ctl_pkg::ADDR_DEEMPH: deemph <= reg_wdata_i;
                reclock_ctl_pkg::ADDR_MUTE_LEVEL: mute_level <= reg_wdata_i;
                reclock_ctl_pkg::ADDR_RATE_VALUE: rate_value <= reg_wdata_i;
                reclock_ctl_pkg::ADDR_RATE_OVR: rate_ovr <= reg_wdata_i;
                reclock_ctl_pkg::ADDR_MANUAL_SEL: manual_sel <= reg_wdata_i;
                default: ; // Read-only and unmapped writes are dropped
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective control levels
    logic override_on;
    logic eff_mute;
    logic eff_bypass;
    logic eff_clk_en;
    logic eff_lock;

    // Override only exists in register mode
    assign override_on = reg_mode_i && pin_override[reclock_ctl_pkg::OVERRIDE_BIT]; // [R16] [R22]
    // Pin mode uses pins only; override makes register mute a no-op
    assign eff_mute = reg_mode_i
        ? (!override_on && level_ctl[reclock_ctl_pkg::MUTE_BIT]) // [R09] [R16]
        : !mute_pin_n_i; // [R08] [R22]
    // Register bypass still acts under override
    assign eff_bypass = (reg_mode_i ? level_ctl[reclock_ctl_pkg::BYPASS_BIT] // [R12]
        : bypass_pin_i) || rate_unsupported_i; // [R11]
    assign eff_clk_en = reg_mode_i
        ? (!override_on && level_ctl[reclock_ctl_pkg::CLK_EN_BIT]) // [R14]
        : clock_out_enable_pin_i; // [R14]
    // Lock indication held low in bypass
    assign eff_lock = pll_locked_i && !eff_bypass; // [R06]

    ////////////////////////////////////////////////////////////////////////
    // Output source selection, pure function of present inputs
    // Table-driven choice when override is clear
    function automatic logic [3:0] auto_select(input logic mute, input logic byp,
                                               input logic clk_en, input logic lock);
        reclock_ctl_pkg::out_src_t a;
        reclock_ctl_pkg::out_src_t b;
        a = reclock_ctl_pkg::SRC_BYPASSED;
        b = reclock_ctl_pkg::SRC_BYPASSED;
        if (mute)
        begin
            a = reclock_ctl_pkg::SRC_MUTE; // [R07]
            b = reclock_ctl_pkg::SRC_MUTE; // [R07]
        end
        else if (byp || !lock)
        begin
            a = reclock_ctl_pkg::SRC_BYPASSED; // [R10] [R15]
            b = clk_en ? reclock_ctl_pkg::SRC_MUTE : reclock_ctl_pkg::SRC_BYPASSED; // [R13]
        end
        else
        begin
            a = reclock_ctl_pkg::SRC_RECLOCKED; // [R15]
            b = clk_en ? reclock_ctl_pkg::SRC_CLOCK : reclock_ctl_pkg::SRC_RECLOCKED;
        end
        return {a, b};
    endfunction : auto_select

    // Manual field decode; bypass turns reclocked data into raw data on both
    function automatic logic [3:0] manual_select(input logic [1:0] sa, input logic [1:0] sb,
                                                 input logic byp, input logic lock);
        reclock_ctl_pkg::out_src_t a;
        reclock_ctl_pkg::out_src_t b;
        unique case (sa)
            2'b01: a = reclock_ctl_pkg::SRC_BYPASSED; // [R17]
            2'b10: a = reclock_ctl_pkg::SRC_MUTE; // [R17]
            default: a = lock ? reclock_ctl_pkg::SRC_RECLOCKED
                : reclock_ctl_pkg::SRC_BYPASSED; // [R17]
        endcase
        unique case (sb)
            2'b00: b = lock ? reclock_ctl_pkg::SRC_CLOCK : reclock_ctl_pkg::SRC_MUTE; // [R18]
            2'b01: b = lock ? reclock_ctl_pkg::SRC_RECLOCKED
                : reclock_ctl_pkg::SRC_BYPASSED; // [R18]
            2'b10: b = reclock_ctl_pkg::SRC_MUTE; // [R18]
            default: b = reclock_ctl_pkg::SRC_BYPASSED; // [R18]
        endcase
        // Bypass replaces reclocked data; clock still turns to mute
        if (byp && a == reclock_ctl_pkg::SRC_RECLOCKED)
            a = reclock_ctl_pkg::SRC_BYPASSED; // [R16]
        if (byp && b == reclock_ctl_pkg::SRC_RECLOCKED)
            b = reclock_ctl_pkg::SRC_BYPASSED; // [R16]
        return {a, b};
    endfunction : manual_select

    logic [3:0] next_sel;

    assign next_sel = override_on
        ? manual_select(manual_sel[reclock_ctl_pkg::SEL_A_LSB +: 2],
                        manual_sel[reclock_ctl_pkg::SEL_B_LSB +: 2], eff_bypass, eff_lock)
        : auto_select(eff_mute, eff_bypass, eff_clk_en, eff_lock); // [R24]

    ////////////////////////////////////////////////////////////////////////
    // Rate selection
    logic [1:0] next_rate;

    // Pins stay in charge until the rate override bit is set in register mode
    assign next_rate = (reg_mode_i && rate_ovr[reclock_ctl_pkg::RATE_OVR_BIT])
        ? rate_value[reclock_ctl_pkg::RATE_LSB +: 2] // [R20]
        : {rate_pin_high_i, rate_pin_low_i}; // [R19]

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    // Driver settings and selection, one cycle behind the inputs
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            out_a_swing_o <= 2'h3;
            out_b_swing_o <= 2'h3;
            outputs_common_mode_o <= 2'h3;
            out_a_deemphasis_o <= 2'h0;
            out_b_deemphasis_o <= 2'h0;
            outputs_invert_o <= 1'b0;
            out_a_powerdown_o <= 1'b0;
            out_b_powerdown_o <= 1'b0;
            out_a_source_o <= reclock_ctl_pkg::SRC_MUTE;
            out_b_source_o <= reclock_ctl_pkg::SRC_MUTE;
            muted_level_o <= 1'b0;
            lock_o <= 1'b0;
            rate_sel_o <= reclock_ctl_pkg::RATE_AUTO_VIDEO;
            eye_monitor_allowed_o <= 1'b0;
        end
        else
        begin
            out_a_swing_o <= level_ctl[reclock_ctl_pkg::SWING_A_LSB +: 2]; // [R01]
            out_b_swing_o <= level_ctl[reclock_ctl_pkg::SWING_B_LSB +: 2]; // [R01]
            outputs_common_mode_o <= drv_cfg_a[reclock_ctl_pkg::CM_LSB +: 2]; // [R02]
            out_a_deemphasis_o <= deemph[reclock_ctl_pkg::DEEMPH_A_LSB +: 2]; // [R03]
            out_b_deemphasis_o <= deemph[reclock_ctl_pkg::DEEMPH_B_LSB +: 2]; // [R03]
            outputs_invert_o <= drv_cfg_a[reclock_ctl_pkg::INV_BIT]; // [R04]
            out_a_powerdown_o <= drv_cfg_a[reclock_ctl_pkg::PD_A_BIT]; // [R05]
            out_b_powerdown_o <= drv_cfg_a[reclock_ctl_pkg::PD_B_BIT]; // [R05]
            out_a_source_o <= next_sel[3:2];
            out_b_source_o <= next_sel[1:0];
            // Pin mode has no way to pick the high mute level
            muted_level_o <= reg_mode_i && mute_level[reclock_ctl_pkg::MUTE_LEVEL_BIT]; // [R09]
            lock_o <= eff_lock; // [R06]
            rate_sel_o <= next_rate;
            eye_monitor_allowed_o <= !eff_bypass; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read path
    // Reads answer one cycle later; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_read_i;
            reg_rdata_o <= 8'h00;
            if (reg_read_i)
            begin
                unique case (reg_addr_i)
                    reclock_ctl_pkg::ADDR_STATUS_LOCK:
                        reg_rdata_o <= 8'(eff_lock) << reclock_ctl_pkg::LOCK_BIT; // [R06]
                    reclock_ctl_pkg::ADDR_PIN_OVERRIDE: reg_rdata_o <= pin_override;
                    reclock_ctl_pkg::ADDR_DRV_CFG_A: reg_rdata_o <= drv_cfg_a;
                    reclock_ctl_pkg::ADDR_LEVEL_CTL: reg_rdata_o <= level_ctl;
                    reclock_ctl_pkg::ADDR_DEEMPH: reg_rdata_o <= deemph;
                    reclock_ctl_pkg::ADDR_MUTE_LEVEL: reg_rdata_o <= mute_level;
                    reclock_ctl_pkg::ADDR_RATE_VALUE: reg_rdata_o <= rate_value;
                    reclock_ctl_pkg::ADDR_RATE_OVR: reg_rdata_o <= rate_ovr;
                    reclock_ctl_pkg::ADDR_MANUAL_SEL: reg_rdata_o <= manual_sel;
                    reclock_ctl_pkg::ADDR_REF_STATUS:
                        reg_rdata_o <= 8'(reference_present_i)
                            << reclock_ctl_pkg::REF_BIT; // [R21]
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Selection change log through the FIFO
    logic [3:0] last_sel;
    logic log_push;
    logic log_ready;
    logic [3:0] fifo_data;
    logic fifo_valid;
    logic out_taken;

    // A change is logged only if it fits; losses are flagged, not hidden
    assign log_push = (next_sel != last_sel);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            last_sel <= 4'h0;
            sel_log_overflow_o <= 1'b0;
        end
        else
        begin
            last_sel <= next_sel;
            if (log_push && !log_ready)
                sel_log_overflow_o <= 1'b1;
        end
    end

    sample_fifo #(.WIDTH(4), .DEPTH(8)) u_log_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_data_i(next_sel),
        .in_valid_i(log_push),
        .in_ready_o(log_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(out_taken)
    );

    // Output stage register keeps the log outputs flop-driven
    assign out_taken = fifo_valid && (!sel_log_valid_o || sel_log_ready_i);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sel_log_valid_o <= 1'b0;
            sel_log_data_o <= 4'h0;
        end
        else if (!sel_log_valid_o || sel_log_ready_i)
        begin
            sel_log_valid_o <= fifo_valid;
            sel_log_data_o <= fifo_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_lock_not_in_bypass;
        @(posedge clk_i) disable iff (sys_rst_i)
        (reg_mode_i && level_ctl[reclock_ctl_pkg::BYPASS_BIT]) |=> !lock_o;
    endproperty
    a_lock_not_in_bypass: assert property (p_lock_not_in_bypass) // [R06]
        else $error("lock shown during bypass");
    property p_mute_wins;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!reg_mode_i && !mute_pin_n_i) |=> (out_a_source_o == 2'b00 && out_b_source_o == 2'b00);
    endproperty
    a_mute_wins: assert property (p_mute_wins) // [R07]
        else $error("outputs not muted");
    property p_clock_muted_unlocked;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!override_on && eff_clk_en && !eff_mute && !pll_locked_i) |=> out_b_source_o == 2'b00;
    endproperty
    a_clock_muted_unlocked: assert property (p_clock_muted_unlocked) // [R13]
        else $error("clock output not muted");
    property p_unsupported_bypass;
        @(posedge clk_i) disable iff (sys_rst_i)
        (rate_unsupported_i && !eff_mute && !override_on) |=> out_a_source_o == 2'b10;
    endproperty
    a_unsupported_bypass: assert property (p_unsupported_bypass) // [R11]
        else $error("no auto bypass");
    property p_manual_a_mute;
        @(posedge clk_i) disable iff (sys_rst_i)
        (override_on && manual_sel[6:5] == 2'b10) |=> out_a_source_o == 2'b00;
    endproperty
    a_manual_a_mute: assert property (p_manual_a_mute) // [R17]
        else $error("manual first output not muted");
    property p_manual_b_clock;
        @(posedge clk_i) disable iff (sys_rst_i)
        (override_on && manual_sel[4:3] == 2'b00 && eff_lock) |=> out_b_source_o == 2'b11;
    endproperty
    a_manual_b_clock: assert property (p_manual_b_clock) // [R18]
        else $error("manual clock not selected");
    property p_rate_override;
        @(posedge clk_i) disable iff (sys_rst_i)
        (reg_mode_i && rate_ovr[0]) |=> rate_sel_o == $past(rate_value[1:0]);
    endproperty
    a_rate_override: assert property (p_rate_override) // [R20]
        else $error("rate register ignored");
    property p_rate_pins;
        @(posedge clk_i) disable iff (sys_rst_i)
        !reg_mode_i |=> rate_sel_o == $past({rate_pin_high_i, rate_pin_low_i});
    endproperty
    a_rate_pins: assert property (p_rate_pins) // [R19]
        else $error("rate pins ignored");
    property p_ref_read;
        @(posedge clk_i) disable iff (sys_rst_i)
        (reg_read_i && reg_addr_i == 8'h41) |=>
            (reg_rvalid_o && reg_rdata_o[3] == $past(reference_present_i));
    endproperty
    a_ref_read: assert property (p_ref_read) // [R21]
        else $error("reference flag read wrong");

    c_reclocked_clock: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        out_a_source_o == 2'b01 && out_b_source_o == 2'b11);
    c_manual_mode: cover property (@(posedge clk_i) disable iff (sys_rst_i) override_on);
    c_log_full: cover property (@(posedge clk_i) disable iff (sys_rst_i) !log_ready);

endmodule : reclock_ctl

/* log_drain.sv */
// Host-side model that drains the selection change log
module log_drain (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic stall_i,
    input wire logic valid_i,
    output logic ready_o,
    output logic [15:0] count_o
);
    // Ready drops only when the bench commands a stall, to back the log up
    assign ready_o = !stall_i;
    // Count entries taken on edges where both sides agree
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            count_o <= 16'h0000;
        end
        else if (valid_i && ready_o)
        begin
            count_o <= count_o + 16'h0001;
        end
    end
endmodule : log_drain

/* reclock_ctl_tb.sv */
// Self-checking bench for the output select control
module reclock_ctl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic mode = 1'b0, mute_n = 1'b1, byp = 1'b0, sco = 1'b0, lkd = 1'b0, uns = 1'b0, wr = 1'b0;
    logic rdr = 1'b0, stall = 1'b0, rvalid, inv, pda, pdb, mlvl, lock, eye, lvalid, lready, ovf;
    logic [1:0] rate_i = 2'h0, swa, swb, cm, dea, deb, srca, srcb, rate;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd;
    logic [15:0] cnt, cnt0;
    logic refp = 1'b1;
    logic [3:0] ldata;
    int miscompares = 0, total_checks = 0;
    // Rows: {mute_n, bypass, clock enable, locked, unsupported} -> {src a, src b, lock}
    logic [4:0] row_in [9] = '{5'h02, 5'h0a, 5'h1a, 5'h1e, 5'h10, 5'h14, 5'h12, 5'h16, 5'h17};
    logic [4:0] row_out [9] = '{5'h01, 5'h00, 5'h14, 5'h10, 5'h14, 5'h10, 5'h0b, 5'h0f, 5'h10};
    logic [1:0] man_a [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
    logic [1:0] man_b [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    always #2.5 clk_i = ~clk_i;
    reclock_ctl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_mode_i(mode),
        .mute_pin_n_i(mute_n), .bypass_pin_i(byp), .clock_out_enable_pin_i(sco),
        .rate_pin_low_i(rate_i[0]), .rate_pin_high_i(rate_i[1]), .pll_locked_i(lkd),
        .rate_unsupported_i(uns), .reference_present_i(refp), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rdr), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .out_a_swing_o(swa), .out_b_swing_o(swb),
        .outputs_common_mode_o(cm), .out_a_deemphasis_o(dea), .out_b_deemphasis_o(deb),
        .outputs_invert_o(inv), .out_a_powerdown_o(pda), .out_b_powerdown_o(pdb),
        .out_a_source_o(srca), .out_b_source_o(srcb), .muted_level_o(mlvl), .lock_o(lock),
        .rate_sel_o(rate), .eye_monitor_allowed_o(eye), .sel_log_data_o(ldata),
        .sel_log_valid_o(lvalid), .sel_log_ready_i(lready), .sel_log_overflow_o(ovf));
    log_drain host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .stall_i(stall), .valid_i(lvalid),
        .ready_o(lready), .count_o(cnt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Outputs are registered once, so two edges cover any input change
    task automatic settle();
        repeat (2) @(negedge clk_i);
    endtask : settle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
        settle();
    endtask : wr_reg
    // Data is taken while the one-cycle valid pulse stands
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_i);
        addr = a;
        rdr = 1'b1;
        @(negedge clk_i);
        rdr = 1'b0;
        while (rvalid !== 1'b1 && n < 4)
        begin
            @(negedge clk_i);
            n++;
        end
        d = rdata;
        chk("rvalid", {7'h00, rvalid}, 8'h01);
    endtask : rd_reg
    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the couple of hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        end_of_test();
    end
    initial
    begin
        repeat (20) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk("swing", {4'h0, swa, swb}, 8'h0f);
        chk("cm_deemph", {2'h0, cm, dea, deb}, 8'h30);
        chk("drv_ctl", {5'h00, inv, pda, pdb}, 8'h00);
        rd_reg(8'h11, rd);
        chk("reg11", rd, 8'hc0);
        for (int i = 0; i < 9; i++)
        begin
            @(negedge clk_i);
            {mute_n, byp, sco, lkd, uns} = row_in[i];
            rate_i = i[1:0];
            settle();
            chk("sources", {3'h0, srca, srcb, lock}, {3'h0, row_out[i]});
            chk("rate", {6'h00, rate}, {6'h00, i[1:0]});
        end
        // Stalled host: ten changes overrun eight slots
        stall = 1'b1;
        chk("log_data", {3'h0, lvalid, ldata}, 8'h18);
        cnt0 = cnt;
        repeat (10)
        begin
            @(negedge clk_i);
            mute_n = ~mute_n;
            settle();
        end
        chk("overflow", {7'h00, ovf}, 8'h01);
        stall = 1'b0;
        repeat (30) @(negedge clk_i);
        chk("drained", {6'h00, lvalid, (cnt - cnt0 >= 16'h0008)}, 8'h01);
        // Register mode ignores the pins, except the rate pins
        {mode, mute_n, byp, lkd, uns} = 5'h16;
        rate_i = 2'h2;
        settle();
        chk("reg_mode", {3'h0, eye, srca, srcb}, 8'h15);
        chk("rate_pins", {6'h00, rate}, 8'h02);
        wr_reg(8'h11, 8'h59);
        wr_reg(8'h12, 8'h92);
        wr_reg(8'h13, 8'hb0);
        wr_reg(8'h14, 8'h80);
        wr_reg(8'h01, 8'hff);
        chk("drv", {cm, dea, deb, swa}, 8'h6e);
        chk("drv2", {swb, inv, pda, pdb, mlvl, 2'h0}, 8'h7c);
        chk("muted", {4'h0, srca, srcb}, 8'h00);
        rd_reg(8'h12, rd);
        chk("reg12", rd, 8'h92);
        wr_reg(8'h12, 8'h94);
        chk("bypass", {3'h0, srca, srcb, lock}, 8'h14);
        chk("eye", {7'h00, eye}, 8'h00);
        wr_reg(8'h12, 8'h91);
        chk("clock", {3'h0, srca, srcb, lock}, 8'h0f);
        rd_reg(8'h01, rd);
        chk("lock_bit", {7'h00, rd[4]}, 8'h01);
        rd_reg(8'h41, rd);
        chk("ref_bit", rd & 8'h08, 8'h08);
        refp = 1'b0;
        rd_reg(8'h41, rd);
        chk("ref_gone", rd, 8'h00);
        rd_reg(8'h50, rd);
        chk("unmapped", rd, 8'h00);
        // Manual selection with register mute set, which must be ignored
        wr_reg(8'h09, 8'h20);
        wr_reg(8'h12, 8'h92);
        for (int j = 0; j < 4; j++)
        begin
            wr_reg(8'h1e, {1'b0, j[1:0], j[1:0], 3'h0});
            chk("manual", {4'h0, srca, srcb}, {4'h0, man_a[j], man_b[j]});
        end
        wr_reg(8'h1e, 8'h00);
        wr_reg(8'h12, 8'h94);
        chk("man_bypass", {4'h0, srca, srcb}, 8'h08);
        wr_reg(8'h1c, 8'h03);
        wr_reg(8'h1d, 8'h01);
        chk("rate_reg", {6'h00, rate}, 8'h03);
        // Reset in mid-run clears the sticky overflow and the registers
        sys_rst_i = 1'b1;
        settle();
        sys_rst_i = 1'b0;
        chk("rerun", {ovf, lock, srca, srcb, rate}, 8'h00);
        rd_reg(8'h12, rd);
        chk("rerun_reg12", rd, 8'hf0);
        end_of_test();
    end
endmodule : reclock_ctl_tb
